// >>> rtl/isbie_pkg.sv
package isbie_pkg;

	// ====================================================
	// Widths and bus address
	localparam int         PORT_W     = 8;
	localparam int         SYNC_W     = 20;
	localparam logic [4:0] ADDR_FIXED = 5'h1D; // Upper five address bits
	localparam logic [3:0] BITS_BYTE  = 4'h8;

	// ====================================================
	// Command byte: bits [2:1] pick the kind, bit 0 the port
	localparam logic [1:0] KIND_INPUT  = 2'h0;
	localparam logic [1:0] KIND_OUTPUT = 2'h1;
	localparam logic [1:0] KIND_POLAR  = 2'h2;
	localparam logic [1:0] KIND_DIR    = 2'h3;
	localparam logic [2:0] CMD_RST     = 3'h0;

	// ====================================================
	// Register values after reset
	localparam logic [7:0] OUT_RST = 8'hFF;
	localparam logic [7:0] POL_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hFF; // All pins inputs

	// ====================================================
	// Protocol states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_AACK  = 3'h3,
		ST_WBYTE = 3'h2,
		ST_WACK  = 3'h6,
		ST_RBYTE = 3'h7,
		ST_RACK  = 3'h5
	} isbie_state_e;

	// ====================================================
	// State of one 8-bit port as seen by the read path
	typedef struct packed {
		logic [7:0] in_val;
		logic [7:0] out_val;
		logic [7:0] pol;
		logic [7:0] dir;
	} isbie_port_s;

endpackage

// >>> rtl/isbie_sync.sv
`timescale 1ns/1ns
module isbie_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output      logic [W-1:0] q
);

	logic [W-1:0] meta;

	// ====================================================
	// Two-stage synchroniser; meta feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

// >>> rtl/isbie_port.sv
`timescale 1ns/1ns
module isbie_port (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [7:0]           pins,
	input  wire logic                 wr_en,
	input  wire logic [1:0]           wr_sel,
	input  wire logic [7:0]           wr_data,
	input  wire logic                 rd_clr,
	output      isbie_pkg::isbie_port_s st,
	output      logic [7:0]           pin_out,
	output      logic [7:0]           pin_oe,
	output      logic                 alert
);

	logic [7:0] out_reg;
	logic [7:0] pol_reg;
	logic [7:0] dir_reg;
	logic [7:0] snap;
	logic       primed;
	logic [1:0] warm;
	logic [7:0] diff;

	// ====================================================
	// Software-written state; writes to the input kind are dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= isbie_pkg::OUT_RST;
			pol_reg <= isbie_pkg::POL_RST;
			dir_reg <= isbie_pkg::DIR_RST;
		end else if (wr_en) begin
			case (wr_sel)
				isbie_pkg::KIND_OUTPUT: out_reg <= wr_data;
				isbie_pkg::KIND_POLAR:  pol_reg <= wr_data;
				isbie_pkg::KIND_DIR:    dir_reg <= wr_data;
				default:                out_reg <= out_reg;
			endcase
		end
	end

	// ====================================================
	// Latched input level; caught once after reset, then per read.
	// The pin synchroniser shows reset zeros for two edges, so the first
	// capture waits for it, else a high pin would alert right after reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snap   <= 8'h00;
			primed <= 1'b0;
			warm   <= 2'h0;
		end else begin
			if (warm != 2'h3) begin
				warm <= warm + 2'h1;
			end
			if (warm == 2'h2 || rd_clr) begin
				snap   <= pins;
				primed <= 1'b1;
			end
		end
	end

	// Only input pins compare; a change in the clear cycle shows next cycle
	assign diff = (pins ^ snap) & dir_reg & {8{primed}};

	// ====================================================
	// Pin drivers and alert, all registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= 8'h00;
			pin_oe  <= 8'h00;
			alert   <= 1'b0;
		end else begin
			pin_out <= out_reg;
			pin_oe  <= ~dir_reg;
			alert   <= |diff;
		end
	end

	// Bit 7 of each byte is pin 7
	assign st = '{in_val: pins ^ pol_reg, out_val: out_reg,
		pol: pol_reg, dir: dir_reg};

	// ====================================================
	// Checks
	property p_alert_set;
		@(posedge clk) disable iff (!rst_n)
		(diff != 8'h00) |=> alert;
	endproperty
	a_alert_set: assert property (p_alert_set)
		else $error("alert not raised on input change");

	property p_out_quiet;
		@(posedge clk) disable iff (!rst_n)
		(((pins ^ snap) & dir_reg) == 8'h00) |=> !alert;
	endproperty
	a_out_quiet: assert property (p_out_quiet)
		else $error("alert raised without input mismatch");

	property p_hiz;
		@(posedge clk) disable iff (!rst_n)
		(dir_reg == 8'hFF) |=> (pin_oe == 8'h00);
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("input pin driven");

	property p_drive;
		@(posedge clk) disable iff (!rst_n)
		##1 ((pin_out & pin_oe) == ($past(out_reg) & ~$past(dir_reg)));
	endproperty
	a_drive: assert property (p_drive)
		else $error("output pin level wrong");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(primed && !rd_clr) |=> (snap == $past(snap));
	endproperty
	a_hold: assert property (p_hold)
		else $error("latched input moved without read");

	property p_polar;
		@(posedge clk) disable iff (!rst_n)
		(pol_reg == 8'hFF) |-> (st.in_val == ~pins);
	endproperty
	a_polar: assert property (p_polar)
		else $error("polarity inversion not applied");

endmodule

// >>> rtl/isbie_top.sv
`timescale 1ns/1ns
// Contract
// - Two independent 8-bit ports with direction, input, output, polarity.
// - After reset every pin of both ports is an input.
// - Input value reads inverted where the polarity bit is set.
// - All eight registers are readable over the bus.
// - Low reset input holds registers and protocol at defaults.
// - Reset input gives the same initialisation as power-on.
// - Alert drives low when an input pin differs from its latched value.
// - Alert releases on level return or read of that port's input.
// - Read release happens at the acknowledge rising edge before data.
// - A change during that acknowledge pulse may be short or lost.
// - After release each new input change raises the alert again.
// - Traffic to other targets leaves alert and latch untouched.
// - Output pins never contribute to the alert.
// - Output to input switch compares and may raise the alert.
// - Alert clearing is per port; one port's read leaves the other.
// - Input pins have both drivers off, high impedance.
// - Output pins are driven to their output register bit.
// - Two select pins give the low address bits; four devices.
// - Device answers addresses 0x74 to 0x77 by select pins.
// - Address LSB one means device sends, zero means write.
// - First written byte is the command; three low bits pick register.
// - Reads stay on the addressed register pair until new command.
module isbie_top (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output      logic       sda_out,
	output      logic       sda_oe,
	input  wire logic       addr_sel_lo,
	input  wire logic       addr_sel_hi,
	input  wire logic [7:0] bank_zero_pins_in,
	output      logic [7:0] bank_zero_pins_out,
	output      logic [7:0] bank_zero_pins_oe,
	input  wire logic [7:0] bank_one_pins_in,
	output      logic [7:0] bank_one_pins_out,
	output      logic [7:0] bank_one_pins_oe,
	output      logic       alert_out,
	output      logic       alert_oe
);

	logic                           rst_q1;
	logic                           rst_n;
	logic [isbie_pkg::SYNC_W-1:0]   sync_q;
	logic                           scl_s;
	logic                           sda_s;
	logic [1:0]                     asel;
	logic                           scl_d;
	logic                           sda_d;
	logic                           scl_rise;
	logic                           scl_fall;
	logic                           start_c;
	logic                           stop_c;
	isbie_pkg::isbie_state_e        state;
	logic [3:0]                     bit_cnt;
	logic [7:0]                     shreg;
	logic                           rw;
	logic                           first;
	logic [2:0]                     cmd;
	logic                           wr_en;
	logic [2:0]                     wr_idx;
	logic [7:0]                     wr_data;
	logic [1:0]                     rd_clr;
	logic [2:0]                     next_idx;
	isbie_pkg::isbie_port_s         st0;
	isbie_pkg::isbie_port_s         st1;
	logic                           alert0;
	logic                           alert1;
	logic                           addr_hit;

	// ====================================================
	// Reset release; the pin reset and power-on share this path
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	// ====================================================
	// Input synchronisers for bus, select and port pins
	isbie_sync #(
		.W (isbie_pkg::SYNC_W)
	) u_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     ({addr_sel_hi, addr_sel_lo, bank_one_pins_in,
			bank_zero_pins_in, sda_in, scl_in}),
		.q     (sync_q)
	);

	assign scl_s = sync_q[0];
	assign sda_s = sync_q[1];
	assign asel  = sync_q[19:18];

	// ====================================================
	// Edge and condition detection on the synchronised lines
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	// Idle bus is trusted to the controller; a START is always taken
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
	assign addr_hit = (shreg[7:1] == {isbie_pkg::ADDR_FIXED, asel});

	// Reads after the first byte move to the pair partner
	assign next_idx = {cmd[2:1], ~cmd[0]};

	// ====================================================
	// Register read mux, index from the command byte
	function automatic logic [7:0] read_reg(input logic [2:0] idx,
		input isbie_pkg::isbie_port_s a, input isbie_pkg::isbie_port_s b);
		isbie_pkg::isbie_port_s p;
		p = idx[0] ? b : a;
		case (idx[2:1])
			isbie_pkg::KIND_INPUT:  read_reg = p.in_val;
			isbie_pkg::KIND_OUTPUT: read_reg = p.out_val;
			isbie_pkg::KIND_POLAR:  read_reg = p.pol;
			default:                read_reg = p.dir;
		endcase
	endfunction

	// ====================================================
	// Target protocol engine; sda_oe high pulls the data line
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= isbie_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			rw      <= 1'b0;
			first   <= 1'b0;
			cmd     <= isbie_pkg::CMD_RST;
			sda_oe  <= 1'b0;
			wr_en   <= 1'b0;
			wr_idx  <= 3'h0;
			wr_data <= 8'h00;
			rd_clr  <= 2'h0;
		end else begin
			wr_en  <= 1'b0;
			rd_clr <= 2'h0;
			if (start_c) begin
				state   <= isbie_pkg::ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else if (stop_c) begin
				state  <= isbie_pkg::ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					isbie_pkg::ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					isbie_pkg::ST_ADDR: begin
						if (scl_rise) begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall &&
							bit_cnt == isbie_pkg::BITS_BYTE) begin
							bit_cnt <= 4'h0;
							// Other targets: stay silent until next START
							if (addr_hit) begin
								state  <= isbie_pkg::ST_AACK;
								sda_oe <= 1'b1;
								rw     <= shreg[0];
							end else begin
								state <= isbie_pkg::ST_IDLE;
							end
						end
					end
					isbie_pkg::ST_AACK: begin
						if (scl_rise && rw) begin
							shreg <= read_reg(cmd, st0, st1);
							if (cmd[2:1] == isbie_pkg::KIND_INPUT)
								rd_clr[cmd[0]] <= 1'b1;
						end else if (scl_fall) begin
							first <= 1'b1;
							if (rw) begin
								state   <= isbie_pkg::ST_RBYTE;
								sda_oe  <= ~shreg[7];
								shreg   <= {shreg[6:0], 1'b0};
								bit_cnt <= 4'h1;
							end else begin
								state   <= isbie_pkg::ST_WBYTE;
								sda_oe  <= 1'b0;
								bit_cnt <= 4'h0;
							end
						end
					end
					isbie_pkg::ST_WBYTE: begin
						if (scl_rise) begin
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall &&
							bit_cnt == isbie_pkg::BITS_BYTE) begin
							state   <= isbie_pkg::ST_WACK;
							sda_oe  <= 1'b1;
							bit_cnt <= 4'h0;
							if (first) begin
								cmd   <= shreg[2:0];
								first <= 1'b0;
							end else begin
								wr_en   <= 1'b1;
								wr_idx  <= cmd;
								wr_data <= shreg;
								cmd     <= next_idx;
							end
						end
					end
					isbie_pkg::ST_WACK: begin
						if (scl_fall) begin
							state  <= isbie_pkg::ST_WBYTE;
							sda_oe <= 1'b0;
						end
					end
					isbie_pkg::ST_RBYTE: begin
						if (scl_fall) begin
							if (bit_cnt == isbie_pkg::BITS_BYTE) begin
								state   <= isbie_pkg::ST_RACK;
								sda_oe  <= 1'b0;
								bit_cnt <= 4'h0;
							end else begin
								sda_oe  <= ~shreg[7];
								shreg   <= {shreg[6:0], 1'b0};
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					isbie_pkg::ST_RACK: begin
						if (scl_rise) begin
							if (sda_s) begin
								state <= isbie_pkg::ST_IDLE;
							end else begin
								// Release and reload in one pulse
								shreg <= read_reg(next_idx, st0, st1);
								cmd   <= next_idx;
								if (next_idx[2:1] == isbie_pkg::KIND_INPUT)
									rd_clr[next_idx[0]] <= 1'b1;
							end
						end else if (scl_fall) begin
							state   <= isbie_pkg::ST_RBYTE;
							sda_oe  <= ~shreg[7];
							shreg   <= {shreg[6:0], 1'b0};
							bit_cnt <= 4'h1;
						end
					end
					default: begin
						state <= isbie_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// ====================================================
	// The two ports
	isbie_port u_port0 (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pins    (sync_q[9:2]),
		.wr_en   (wr_en & ~wr_idx[0]),
		.wr_sel  (wr_idx[2:1]),
		.wr_data (wr_data),
		.rd_clr  (rd_clr[0]),
		.st      (st0),
		.pin_out (bank_zero_pins_out),
		.pin_oe  (bank_zero_pins_oe),
		.alert   (alert0)
	);

	isbie_port u_port1 (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.pins    (sync_q[17:10]),
		.wr_en   (wr_en & wr_idx[0]),
		.wr_sel  (wr_idx[2:1]),
		.wr_data (wr_data),
		.rd_clr  (rd_clr[1]),
		.st      (st1),
		.pin_out (bank_one_pins_out),
		.pin_oe  (bank_one_pins_oe),
		.alert   (alert1)
	);

	// ====================================================
	// Open-drain outputs; the driven level is always low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_oe  <= 1'b0;
			alert_out <= 1'b0;
			sda_out   <= 1'b0;
		end else begin
			alert_oe  <= alert0 | alert1;
			alert_out <= 1'b0;
			sda_out   <= 1'b0;
		end
	end

	// ====================================================
	// Checks
	property p_ack_match;
		@(posedge ref_clk) disable iff (!rst_n)
		(state == isbie_pkg::ST_ADDR && scl_fall && !start_c && !stop_c &&
			bit_cnt == isbie_pkg::BITS_BYTE && !addr_hit)
			|=> (state == isbie_pkg::ST_IDLE && !sda_oe);
	endproperty
	a_ack_match: assert property (p_ack_match)
		else $error("foreign address acknowledged");

	property p_clr_when;
		@(posedge ref_clk) disable iff (!rst_n)
		(rd_clr != 2'h0) |-> $past(scl_rise) &&
			($past(state) == isbie_pkg::ST_AACK ||
			$past(state) == isbie_pkg::ST_RACK);
	endproperty
	a_clr_when: assert property (p_clr_when)
		else $error("alert cleared outside read acknowledge");

	property p_clr_port;
		@(posedge ref_clk) disable iff (!rst_n)
		(rd_clr != 2'h0) |-> (rd_clr != 2'h3);
	endproperty
	a_clr_port: assert property (p_clr_port)
		else $error("both ports cleared by one read");

	property p_read_dir;
		@(posedge ref_clk) disable iff (!rst_n)
		(state == isbie_pkg::ST_RBYTE) |-> rw;
	endproperty
	a_read_dir: assert property (p_read_dir)
		else $error("sending data on a write");

	property p_cmd_hold;
		@(posedge ref_clk) disable iff (!rst_n)
		(state inside {isbie_pkg::ST_IDLE, isbie_pkg::ST_ADDR,
			isbie_pkg::ST_AACK}) |=> (cmd == $past(cmd));
	endproperty
	a_cmd_hold: assert property (p_cmd_hold)
		else $error("command changed without a byte");

	c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
		wr_en);
	c_read_clr: cover property (@(posedge ref_clk) disable iff (!rst_n)
		rd_clr[1]);
	c_alert: cover property (@(posedge ref_clk) disable iff (!rst_n)
		alert_oe ##1 !alert_oe);

endmodule

// >>> tb/isbie_ctrl_model.sv
`timescale 1ns/1ns
// ==========================================================
// Bus controller model: open drain on data, it only pulls sda low; scl is driven both ways
module isbie_ctrl_model (
	input  wire logic ref_clk,
	input  wire logic sda,
	output      logic scl,
	output      logic sda_low
);
	logic [6:0] dev_addr;
	int         phase = 12; // Clocks per half bit, above the 10 minimum

	// Both lines released at time zero, so the bus starts idle
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		dev_addr = 7'h74;
	end

	// ==========================================================
	// Bit timing
	task automatic tick();
		repeat (phase) @(posedge ref_clk);
		#1;
	endtask

	// Keeps data changes clear of the clock fall after synchronising
	task automatic gap();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	// START only from an idle bus with both lines high
	task automatic start();
		tick();
		sda_low = 1'b1;
		tick();
		scl = 1'b0;
		gap();
	endtask

	// STOP leaves both lines high, so the next START sees an idle bus
	task automatic stop();
		sda_low = 1'b1;
		tick();
		scl = 1'b1;
		tick();
		sda_low = 1'b0;
		tick();
	endtask

	// Data moves in the low phase; the line is read late in the high phase
	task automatic bit_io(input logic b, output logic s);
		sda_low = ~b;
		tick();
		scl = 1'b1;
		tick();
		s = sda;
		scl = 1'b0;
		gap();
	endtask

	task automatic byte_io(input logic [7:0] b, input logic ack_in,
		output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(ack_in, ack);
	endtask

	// ==========================================================
	// Transfers
	task automatic probe(output logic ok);
		logic [7:0] r;
		logic       a;
		start();
		byte_io({dev_addr, 1'b0}, 1'b1, r, a);
		stop();
		ok = ~a;
	endtask

	task automatic reg_write(input logic [2:0] cmd, input logic [7:0] d0,
		input logic [7:0] d1, output logic ok);
		logic [7:0] r;
		logic [3:0] a;
		start();
		byte_io({dev_addr, 1'b0}, 1'b1, r, a[0]);
		byte_io({5'h00, cmd}, 1'b1, r, a[1]);
		byte_io(d0, 1'b1, r, a[2]);
		byte_io(d1, 1'b1, r, a[3]);
		stop();
		ok = (a == 4'h0);
	endtask

	// Optional command write, then one or two bytes, the last one refused
	task automatic reg_read(input logic cmd_en, input logic [2:0] cmd,
		input logic two, output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] r;
		logic       a;
		if (cmd_en) begin
			start();
			byte_io({dev_addr, 1'b0}, 1'b1, r, a);
			byte_io({5'h00, cmd}, 1'b1, r, a);
			stop();
		end
		start();
		byte_io({dev_addr, 1'b1}, 1'b1, r, a);
		byte_io(8'hFF, ~two, r0, a);
		r1 = 8'h00;
		if (two) begin
			byte_io(8'hFF, 1'b1, r1, a);
		end
		stop();
	endtask
endmodule

// >>> tb/test_isbie_top.sv
`timescale 1ns/1ns
// ==========================================================
// Bench for the two-port expander
module test_isbie_top;
	logic       ref_clk;
	logic       arst_n;
	logic       addr_sel_lo;
	logic       addr_sel_hi;
	logic [7:0] ext0;
	logic [7:0] ext1;
	logic       scl;
	logic       sda_low;
	logic       sda_out;
	logic       sda_oe;
	logic       alert_out;
	logic       alert_oe;
	logic [7:0] p0_in;
	logic [7:0] p0_out;
	logic [7:0] p0_oe;
	logic [7:0] p1_in;
	logic [7:0] p1_out;
	logic [7:0] p1_oe;
	logic [7:0] r0;
	logic [7:0] r1;
	logic       ok;
	wire        sda;
	int         err_count = 0;
	int         compares = 0;

	// Wired-AND data line with pull-up; driven pins show their own level
	assign sda = ~sda_low & (~sda_oe | sda_out);
	assign p0_in = (p0_oe & p0_out) | (~p0_oe & ext0);
	assign p1_in = (p1_oe & p1_out) | (~p1_oe & ext1);

	// Free running clock, 4 ns period
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	isbie_top i_dut (
		.ref_clk            (ref_clk),
		.arst_n             (arst_n),
		.scl_in             (scl),
		.sda_in             (sda),
		.sda_out            (sda_out),
		.sda_oe             (sda_oe),
		.addr_sel_lo        (addr_sel_lo),
		.addr_sel_hi        (addr_sel_hi),
		.bank_zero_pins_in  (p0_in),
		.bank_zero_pins_out (p0_out),
		.bank_zero_pins_oe  (p0_oe),
		.bank_one_pins_in   (p1_in),
		.bank_one_pins_out  (p1_out),
		.bank_one_pins_oe   (p1_oe),
		.alert_out          (alert_out),
		.alert_oe           (alert_oe)
	);

	isbie_ctrl_model i_ctrl (
		.ref_clk (ref_clk),
		.sda     (sda),
		.scl     (scl),
		.sda_low (sda_low)
	);

	// ==========================================================
	// Helpers
	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	task automatic chk_al(input string name, input logic exp);
		chk(name, {15'h0000, exp}, {14'h0000, alert_out, alert_oe});
	endtask

	// Long enough for the four clock alert path to land
	task automatic settle();
		repeat (10) @(posedge ref_clk);
		#1;
	endtask

	task automatic set_pins(input logic [7:0] a, input logic [7:0] b);
		@(posedge ref_clk);
		#1;
		ext0 = a;
		ext1 = b;
		settle();
	endtask

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("pin enables", 16'h0000, {p1_oe, p0_oe});
		chk("pin levels", 16'hFFFF, {p1_out, p0_out});
		chk_al("alert idle", 1'b0);
		i_ctrl.reg_read(1'b1, 3'h6, 1'b1, r0, r1);
		chk("dir regs", 16'hFFFF, {r0, r1});
		i_ctrl.reg_read(1'b1, 3'h2, 1'b1, r0, r1);
		chk("out regs", 16'hFFFF, {r0, r1});
		i_ctrl.reg_read(1'b1, 3'h4, 1'b1, r0, r1);
		chk("pol regs", 16'h0000, {r0, r1});
		$display("test reset done");
	endtask

	// Every select setting against every address of the family
	task automatic t_addr();
		for (int s = 0; s < 4; s++) begin
			{addr_sel_hi, addr_sel_lo} = 2'(s);
			for (int t = 0; t < 4; t++) begin
				i_ctrl.dev_addr = 7'h74 + 7'(t);
				i_ctrl.probe(ok);
				chk("addr ack", {15'h0000, t == s}, {15'h0000, ok});
			end
		end
		{addr_sel_hi, addr_sel_lo} = 2'h0;
		i_ctrl.dev_addr = 7'h74;
		$display("test address done");
	endtask

	task automatic t_regs();
		i_ctrl.reg_write(3'h6, 8'h0F, 8'hF0, ok);
		chk("write ack", 16'h0001, {15'h0000, ok});
		i_ctrl.reg_write(3'h3, 8'h3C, 8'hA5, ok);
		settle();
		chk("pin enables", 16'h0FF0, {p1_oe, p0_oe});
		chk("pin levels", 16'h3CA5, {p1_out, p0_out});
		i_ctrl.reg_read(1'b1, 3'h2, 1'b1, r0, r1);
		chk("out pair", 16'hA53C, {r0, r1});
		i_ctrl.reg_read(1'b0, 3'h0, 1'b1, r0, r1);
		chk("repeat read", 16'h3CA5, {r0, r1});
		i_ctrl.reg_read(1'b1, 3'h7, 1'b1, r0, r1);
		chk("dir pair", 16'hF00F, {r0, r1});
		set_pins(8'h96, 8'h5A);
		i_ctrl.reg_write(3'h4, 8'hFF, 8'h00, ok);
		i_ctrl.reg_read(1'b1, 3'h0, 1'b1, r0, r1);
		chk("inputs", 16'h595C, {r0, r1});
		$display("test registers done");
	endtask

	task automatic t_alert();
		set_pins(8'h00, 8'h00);
		@(posedge ref_clk);
		#1;
		arst_n = 1'b0;
		repeat (12) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		settle();
		chk("pin enables", 16'h0000, {p1_oe, p0_oe});
		i_ctrl.reg_read(1'b1, 3'h6, 1'b1, r0, r1);
		chk("dir regs", 16'hFFFF, {r0, r1});
		set_pins(8'h04, 8'h00);
		chk_al("alert raise", 1'b1);
		set_pins(8'h00, 8'h00);
		chk_al("alert level return", 1'b0);
		set_pins(8'h04, 8'h00);
		i_ctrl.dev_addr = 7'h75;
		i_ctrl.probe(ok);
		i_ctrl.dev_addr = 7'h74;
		chk_al("alert other target", 1'b1);
		i_ctrl.reg_read(1'b1, 3'h1, 1'b0, r0, r1);
		settle();
		chk_al("alert other port", 1'b1);
		i_ctrl.reg_read(1'b1, 3'h0, 1'b0, r0, r1);
		settle();
		chk_al("alert read clear", 1'b0);
		chk("port zero input", 16'h0004, {8'h00, r0});
		set_pins(8'h04, 8'h80);
		chk_al("alert again", 1'b1);
		i_ctrl.reg_read(1'b1, 3'h0, 1'b0, r0, r1);
		settle();
		chk_al("alert port one kept", 1'b1);
		i_ctrl.reg_read(1'b1, 3'h1, 1'b0, r0, r1);
		settle();
		chk_al("alert port one clear", 1'b0);
		chk("port one input", 16'h0080, {8'h00, r0});
		i_ctrl.reg_write(3'h6, 8'hFE, 8'hFF, ok);
		i_ctrl.reg_write(3'h2, 8'h01, 8'hFF, ok);
		set_pins(8'h05, 8'h80);
		chk_al("alert output pin", 1'b0);
		i_ctrl.reg_write(3'h6, 8'hFF, 8'hFF, ok);
		settle();
		chk_al("alert back to input", 1'b1);
		$display("test alert done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		arst_n = 1'b0;
		addr_sel_lo = 1'b0;
		addr_sel_hi = 1'b0;
		ext0 = 8'h00;
		ext1 = 8'h00;
		repeat (12) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		settle();
		t_reset();
		t_addr();
		t_regs();
		t_alert();
		close_out();
	end

	// Hang guard: the scenarios need about 105 us
	initial begin
		#300000;
		$display("[FAIL] watchdog expected done seen running");
		err_count++;
		close_out();
	end
endmodule
